//--- sdp_params.svh
// Function
// RULE1 - select when low enable low, high high
// RULE2 - single read: data after next edge
// RULE3 - output enable asynchronous, rest edge sampled
// RULE4 - deselect floats data after next edge
// RULE5 - read to write frees pins first
// RULE6 - strobe and advance low load address
// RULE7 - output state set by previous cycle
// RULE8 - host rewrites location after bank switch
// RULE9 - counter clear costs no dead cycle
// RULE10 - host releases address bus for readback
// RULE11 - host drives address after device releases
// RULE12 - readback shows counter or mask value
// RULE13 - wrap flag low at unmasked maximum
// RULE14 - increment after wrap repeats from base
// RULE15 - top small-array address is mailbox
// RULE16 - host asserts a byte enable for mailbox
// RULE17 - flag set on write, cleared on read
// RULE18 - decode deselect, write, read, outputs off
// RULE19 - select change takes one cycle latency
// RULE20 - address 17 or 18 bits wide
// RULE21 - master reset held five cycles
// RULE22 - five cycles after reset before access
// RULE23 - master reset clears wrap flag
// RULE24 - far write sets, own read clears flag
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH
`define SDP_DATA_W        72
`define SDP_ADDR_W        17
`define SDP_BYTE_N        8
`define SDP_MBOX_OWN      32'h0001ffff
`define SDP_MBOX_FAR      32'h0001fffe
`define SDP_MASK_RST      32'hffffffff
`define SDP_REG_MASK      8'h00
`define SDP_REG_COUNT     8'h04
`define SDP_REG_STATUS    8'h08
`define SDP_REG_BASE      8'h0c
`define SDP_ST_WRAP_BIT   0
`define SDP_ST_MSG_BIT    1
`define SDP_RST_HOLD_CYC  5
`define SDP_RST_RECOV_CYC 5
`endif

//--- sdp_pkg.sv
`include "sdp_params.svh"
package sdp_pkg;
   // counter operation decoded from the sampled pins
   typedef enum logic [2:0] {
      CNT_HOLD  = 3'b000,
      CNT_LOAD  = 3'b001,
      CNT_INC   = 3'b010,
      CNT_CLEAR = 3'b011,
      CNT_MASK  = 3'b100,
      CNT_RDBK  = 3'b101
   } sdp_cnt_op_t;
   // synchronised port controls
   typedef struct packed {
      logic                   sel;
      logic                   rd;
      logic                   strobe_n;
      logic                   adv_n;
      logic                   clr_n;
      logic                   cm_sel;
      logic [`SDP_BYTE_N-1:0] be_n;
   } sdp_ctl_t;
endpackage

//--- sdp_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdp_params.svh"
module sdp_counter #(
   parameter int ADDR_W = `SDP_ADDR_W
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   // operation
   input  wire sdp_pkg::sdp_cnt_op_t op,
   input  wire logic [ADDR_W-1:0] ext_addr,
   input  wire logic              sw_mask_we,
   input  wire logic [ADDR_W-1:0] sw_mask_val,
   // state
   output logic      [ADDR_W-1:0] cnt,
   output logic      [ADDR_W-1:0] mask,
   output logic      [ADDR_W-1:0] base,
   output logic      [ADDR_W-1:0] eff_addr,
   output logic                   wrap_n
);
   logic [ADDR_W-1:0] next_cnt;
   logic [ADDR_W-1:0] next_mask;
   logic [ADDR_W-1:0] next_base;
   logic              next_wrap_n;

   // masked bits hold, unmasked bits count, wrap returns to base
   always_comb begin
      next_cnt    = cnt;
      next_mask   = mask;
      next_base   = base;
      next_wrap_n = wrap_n;
      case (op)
         sdp_pkg::CNT_LOAD: begin
            next_cnt    = ext_addr;
            next_base   = ext_addr;
            next_wrap_n = 1'b1;
         end
         sdp_pkg::CNT_CLEAR: begin
            next_cnt    = '0; // [RULE9]
            next_base   = '0;
            next_wrap_n = 1'b1;
         end
         sdp_pkg::CNT_INC: begin
            if ((cnt & mask) == mask) begin
               next_cnt = base; // [RULE14]
            end else begin
               next_cnt = (((cnt | ~mask) + ADDR_W'(1)) & mask) | (cnt & ~mask);
            end
            if ((next_cnt & mask) == mask) begin
               next_wrap_n = 1'b0; // [RULE13]
            end
         end
         sdp_pkg::CNT_MASK: begin
            next_mask = ext_addr;
         end
         default: begin
         end
      endcase
      if (sw_mask_we) begin
         next_mask = sw_mask_val;
      end
   end

   // access uses the address formed in this same cycle
   assign eff_addr = next_cnt;

   // wrap flag inactive out of reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt    <= '0;
         mask   <= ADDR_W'(`SDP_MASK_RST);
         base   <= '0;
         wrap_n <= 1'b1; // [RULE23]
      end else if (clk_en) begin
         cnt    <= next_cnt;
         mask   <= next_mask;
         base   <= next_base;
         wrap_n <= next_wrap_n;
      end
   end
endmodule
`default_nettype wire

//--- sdp_mailbox.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_mailbox (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // events
   input  wire logic far_set,
   input  wire logic own_clr,
   // flag
   output logic      msg_n
);
   logic next_msg_n;

   // a set in the clearing cycle wins so no message is lost
   always_comb begin
      next_msg_n = msg_n;
      if (far_set) begin
         next_msg_n = 1'b0; // [RULE24]
      end else if (own_clr) begin
         next_msg_n = 1'b1; // [RULE17]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         msg_n <= 1'b1;
      end else if (clk_en) begin
         msg_n <= next_msg_n;
      end
   end
endmodule
`default_nettype wire

//--- sdp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdp_params.svh"
module sdp_port #(
   parameter int                ADDR_W   = `SDP_ADDR_W, // [RULE20]
   parameter int                DATA_W   = `SDP_DATA_W,
   parameter int                BYTE_N   = `SDP_BYTE_N,
   parameter logic [ADDR_W-1:0] MBOX_OWN = ADDR_W'(`SDP_MBOX_OWN),
   parameter logic [ADDR_W-1:0] MBOX_FAR = ADDR_W'(`SDP_MBOX_FAR)
) (
   // clock, reset, enable
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   // port control pins
   input  wire logic              chip_sel_low_active,
   input  wire logic              chip_sel_high_active,
   input  wire logic              read_not_write,
   input  wire logic              out_en_n,
   input  wire logic              address_strobe_n,
   input  wire logic              counter_advance_n,
   input  wire logic              counter_clear_n,
   input  wire logic              counter_or_mask_select,
   input  wire logic [BYTE_N-1:0] byte_lane_enable_n,
   // address pins
   input  wire logic [ADDR_W-1:0] addr_in,
   output logic      [ADDR_W-1:0] addr_out,
   output logic      [ADDR_W-1:0] addr_oe,
   // data pins
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] data_out,
   output logic      [DATA_W-1:0] data_oe,
   // flags
   output logic                   counter_wrap_flag_n,
   output logic                   msg_flag_n,
   // mailbox link to the opposite port
   input  wire logic              far_mbox_wr,
   output logic                   near_mbox_wr,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o
);
   localparam int SYNC_W = 7 + BYTE_N + ADDR_W + DATA_W;
   // each enable owns a full lane, so no data bit is left without one
   localparam int LANE_W = DATA_W / BYTE_N;

   logic [SYNC_W-1:0]     pin_raw;
   logic [SYNC_W-1:0]     sync1;
   logic [SYNC_W-1:0]     sync2;
   logic [SYNC_W-1:0]     next_sync1;
   logic [SYNC_W-1:0]     next_sync2;
   logic                  s_sel_lo;
   logic                  s_sel_hi;
   logic                  s_rd;
   logic                  s_strobe_n;
   logic                  s_adv_n;
   logic                  s_clr_n;
   logic                  s_cm;
   logic [BYTE_N-1:0]     s_be_n;
   logic [ADDR_W-1:0]     s_addr;
   logic [DATA_W-1:0]     s_data;
   sdp_pkg::sdp_ctl_t     ctl;
   sdp_pkg::sdp_cnt_op_t  op;
   logic                  access;
   logic                  do_read;
   logic                  do_write;
   logic                  any_be;
   logic                  own_clr;
   logic [ADDR_W-1:0]     cnt;
   logic [ADDR_W-1:0]     mask;
   logic [ADDR_W-1:0]     base;
   logic [ADDR_W-1:0]     eff_addr;
   logic                  sw_mask_we;
   logic [ADDR_W-1:0]     sw_mask_val;
   logic [DATA_W-1:0]     mem [0:(2**ADDR_W)-1];
   logic                  rd_pend;
   logic [ADDR_W-1:0]     rd_addr;
   logic [BYTE_N-1:0]     rd_be_n;
   logic [BYTE_N-1:0]     dq_drive;
   logic                  rb_drive;
   logic                  next_rd_pend;
   logic [ADDR_W-1:0]     next_rd_addr;
   logic [BYTE_N-1:0]     next_rd_be_n;
   logic [BYTE_N-1:0]     next_dq_drive;
   logic [DATA_W-1:0]     next_data_out;
   logic                  next_rb_drive;
   logic [ADDR_W-1:0]     next_addr_out;
   logic                  next_near_mbox_wr;
   logic                  wb_hit;
   logic                  next_wb_ack;
   logic [31:0]           next_wb_dat;

   // pins other than the output enable cross into the clock domain through two stages
   assign pin_raw = {chip_sel_low_active, chip_sel_high_active, read_not_write,
                     address_strobe_n, counter_advance_n, counter_clear_n,
                     counter_or_mask_select, byte_lane_enable_n, addr_in, data_in};

   always_comb begin
      next_sync1 = pin_raw;
      next_sync2 = sync1;
   end

   // idle is all ones: deselected, counter holding
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= '1;
         sync2 <= '1;
      end else if (clk_en) begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   assign {s_sel_lo, s_sel_hi, s_rd, s_strobe_n, s_adv_n, s_clr_n, s_cm,
           s_be_n, s_addr, s_data} = sync2;

   // sampled controls and operation decode
   assign ctl.sel      = ~s_sel_lo & s_sel_hi; // [RULE1]
   assign ctl.rd       = s_rd;
   assign ctl.strobe_n = s_strobe_n;
   assign ctl.adv_n  = s_adv_n;
   assign ctl.clr_n  = s_clr_n;
   assign ctl.cm_sel = s_cm;
   assign ctl.be_n   = s_be_n;

   // clear outranks load so the access lands on address zero
   always_comb begin
      op = sdp_pkg::CNT_HOLD;
      if (!ctl.clr_n) begin
         op = sdp_pkg::CNT_CLEAR; // [RULE9]
      end else if (ctl.cm_sel && !ctl.strobe_n && !ctl.adv_n) begin
         op = sdp_pkg::CNT_LOAD; // [RULE6]
      end else if (ctl.cm_sel && ctl.strobe_n && !ctl.adv_n) begin
         op = sdp_pkg::CNT_INC;
      end else if (!ctl.cm_sel && !ctl.strobe_n && !ctl.adv_n) begin
         op = sdp_pkg::CNT_MASK;
      end else if (!ctl.strobe_n && ctl.adv_n) begin
         op = sdp_pkg::CNT_RDBK;
      end
   end

   // mask load and readback cycles carry no memory access
   assign access   = (op != sdp_pkg::CNT_MASK) && (op != sdp_pkg::CNT_RDBK);
   assign do_write = ctl.sel & ~ctl.rd & access; // [RULE18]
   assign do_read  = ctl.sel & ctl.rd & access;  // [RULE18]
   assign any_be   = ~&ctl.be_n;

   sdp_counter #(
      .ADDR_W      (ADDR_W)
   ) u_counter (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .op          (op),
      .ext_addr    (s_addr),
      .sw_mask_we  (sw_mask_we),
      .sw_mask_val (sw_mask_val),
      .cnt         (cnt),
      .mask        (mask),
      .base        (base),
      .eff_addr    (eff_addr),
      .wrap_n      (counter_wrap_flag_n)
   );

   // mailbox events need a byte enable, as the host is told
   assign own_clr = do_read & any_be & (eff_addr == MBOX_OWN); // [RULE15] [RULE16]
   assign next_near_mbox_wr = do_write & any_be & (eff_addr == MBOX_FAR);

   sdp_mailbox u_mailbox (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .far_set (far_mbox_wr),
      .own_clr (own_clr),
      .msg_n   (msg_flag_n)
   );

   // byte-lane writes; the array has no reset
   always_ff @(posedge sys_clk) begin
      if (clk_en && do_write) begin
         for (int b = 0; b < BYTE_N; b++) begin
            if (!ctl.be_n[b]) begin
               mem[eff_addr][b*LANE_W +: LANE_W] <= s_data[b*LANE_W +: LANE_W];
            end
         end
      end
   end

   // read pipeline: sample, then fetch and drive one edge later
   always_comb begin
      next_rd_pend  = do_read; // [RULE2]
      next_rd_addr  = eff_addr;
      next_rd_be_n  = ctl.be_n;
      next_data_out = rd_pend ? mem[rd_addr] : data_out;
      // a sampled write frees the pins at once, the host needs no no-op
      next_dq_drive = (rd_pend && !do_write) ? ~rd_be_n : '0; // [RULE5] [RULE7] [RULE19]
      next_rb_drive = (op == sdp_pkg::CNT_RDBK); // [RULE10] [RULE11]
      next_addr_out = ctl.cm_sel ? cnt : mask;   // [RULE12]
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend      <= 1'b0;
         rd_addr      <= '0;
         rd_be_n      <= '1;
         data_out     <= '0;
         dq_drive     <= '0;
         rb_drive     <= 1'b0;
         addr_out     <= '0;
         near_mbox_wr <= 1'b0;
      end else if (clk_en) begin
         rd_pend      <= next_rd_pend;
         rd_addr      <= next_rd_addr;
         rd_be_n      <= next_rd_be_n;
         data_out     <= next_data_out;
         dq_drive     <= next_dq_drive;
         rb_drive     <= next_rb_drive;
         addr_out     <= next_addr_out;
         near_mbox_wr <= next_near_mbox_wr;
      end
   end

   // output enable pin gates the lanes with no clock in the path
   for (genvar g = 0; g < BYTE_N; g++) begin : g_lane
      assign data_oe[g*LANE_W +: LANE_W] = {LANE_W{dq_drive[g] & ~out_en_n}}; // [RULE3] [RULE4]
   end
   assign addr_oe = {ADDR_W{rb_drive}};

   // wishbone: ack one cycle after the request, writes land on the ack edge
   assign wb_hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign sw_mask_we = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == `SDP_REG_MASK);

   always_comb begin
      logic [31:0] merged;
      merged = 32'(mask);
      for (int i = 0; i < 4; i++) begin
         if (wb_sel_i[i]) begin
            merged[i*8 +: 8] = wb_dat_i[i*8 +: 8];
         end
      end
      sw_mask_val = merged[ADDR_W-1:0];
      next_wb_ack = wb_hit;
      next_wb_dat = wb_dat_o;
      if (wb_hit) begin
         case (wb_adr_i)
            `SDP_REG_MASK:   next_wb_dat = 32'(mask);
            `SDP_REG_COUNT:  next_wb_dat = 32'(cnt);
            `SDP_REG_BASE:   next_wb_dat = 32'(base);
            `SDP_REG_STATUS: begin
               next_wb_dat = 32'h0000_0000;
               next_wb_dat[`SDP_ST_WRAP_BIT] = ~counter_wrap_flag_n;
               next_wb_dat[`SDP_ST_MSG_BIT]  = ~msg_flag_n;
            end
            default:         next_wb_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clk_en) begin
         wb_ack_o <= next_wb_ack;
         wb_dat_o <= next_wb_dat;
      end
   end

   // checks count only enabled edges
   default clocking cb @(posedge sys_clk iff clk_en);
   endclocking
   default disable iff (!rst_n);

   read_drive_a: assert property ((do_read && any_be) ##1 !do_write |=> (|dq_drive)) // [RULE2]
      else $error("sampled read did not drive data");
   desel_float_a: assert property (!ctl.sel |=> ##1 (dq_drive == '0)) // [RULE4]
      else $error("data still driven after deselect");
   oe_async_a: assert property (out_en_n |-> (data_oe == '0)) // [RULE3]
      else $error("data driven with output enable high");
   write_free_a: assert property (do_write |=> (dq_drive == '0)) // [RULE5]
      else $error("pins not freed on write");
   prev_ctl_a: assert property (!rd_pend |=> (dq_drive == '0)) // [RULE7]
      else $error("drive without pending read");
   load_addr_a: assert property (op == sdp_pkg::CNT_LOAD |=> (cnt == $past(s_addr))) // [RULE6]
      else $error("address not loaded");
   clear_access_a: assert property ((op == sdp_pkg::CNT_CLEAR) && do_read // [RULE9]
                                    |=> rd_pend && (rd_addr == '0))
      else $error("clear cycle lost its access");
   readback_val_a: assert property (op == sdp_pkg::CNT_RDBK |=> (addr_oe == '1) && // [RULE12]
      (addr_out == ($past(ctl.cm_sel) ? $past(cnt) : $past(mask))))
      else $error("readback value wrong");
   wrap_flag_a: assert property ((op == sdp_pkg::CNT_INC) // [RULE13]
                                 && ((eff_addr & mask) == mask) |=> !counter_wrap_flag_n)
      else $error("wrap flag not set");
   retransmit_a: assert property ((op == sdp_pkg::CNT_INC) // [RULE14]
                                  && ((cnt & mask) == mask) |=> (cnt == $past(base)))
      else $error("no return to base");
   mbox_set_a: assert property (far_mbox_wr |=> !msg_flag_n) // [RULE24]
      else $error("message flag not set");
   mbox_clr_a: assert property (own_clr && !far_mbox_wr |=> msg_flag_n) // [RULE17]
      else $error("message flag not cleared");
   wb_ack_a: assert property (wb_hit |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not one cycle");

   cov_read_c:     cover property (do_read ##2 (|data_oe));
   cov_write_c:    cover property (do_write && any_be);
   cov_readback_c: cover property (op == sdp_pkg::CNT_RDBK ##1 rb_drive);
   cov_wrap_c:     cover property ($fell(counter_wrap_flag_n));
   cov_mbox_c:     cover property (far_mbox_wr ##[1:20] own_clr);
endmodule
`default_nettype wire

//--- sdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // host drive
   input  wire logic        host_a_en,
   input  wire logic [16:0] host_a,
   input  wire logic        host_d_en,
   input  wire logic [71:0] host_d,
   // device drive
   input  wire logic [16:0] addr_out,
   input  wire logic [16:0] addr_oe,
   input  wire logic [71:0] data_out,
   input  wire logic [71:0] data_oe,
   // resolved pin levels
   output logic      [16:0] addr_w,
   output logic      [71:0] data_w
);
   logic [16:0] a_last;
   logic [71:0] d_last;
   logic        a_drv;
   logic        d_drv;
   // host never fights the device on the address pins
   assign a_drv = host_a_en & ~(|addr_oe);
   assign d_drv = host_d_en & ~(|data_oe);
   // a released line shows the inverse of its last level, no keeper on the pins
   always_comb begin
      addr_w = (addr_oe & addr_out) | (~addr_oe & (a_drv ? host_a : ~a_last));
      data_w = (data_oe & data_out) | (~data_oe & (d_drv ? host_d : ~d_last));
   end
   // last level of each line
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_last <= '0;
         d_last <= '0;
      end else begin
         a_last <= addr_w;
         d_last <= data_w;
      end
   end
endmodule
`default_nettype wire

//--- sdp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdp_params.svh"
module sdp_port_tb;
   typedef struct packed {
      logic [7:0]  adr;
      logic [31:0] exp;
   } sdp_row_t;
   logic        sys_clk = 0;
   logic        rst_n = 0;
   logic        sel_lo = 0;
   logic        sel_hi = 0;
   logic        rnw = 1;
   logic        oe_n = 0;
   logic        strobe_n = 1;
   logic        adv_n = 1;
   logic        clr_n = 1;
   logic        cm = 1;
   logic [7:0]  be_n = 8'hff;
   logic        host_a_en = 0;
   logic [16:0] host_a = '0;
   logic        host_d_en = 0;
   logic [71:0] host_d = '0;
   logic        far_wr = 0;
   logic        wb_cyc = 0;
   logic        wb_stb = 0;
   logic        wb_we = 0;
   logic [7:0]  wb_adr = '0;
   logic [31:0] wb_dat = '0;
   logic [16:0] addr_w, addr_out, addr_oe;
   logic [71:0] data_w, data_out, data_oe;
   logic        wrap_n, msg_n, near_wr, wb_ack;
   logic [31:0] wb_q, q;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          k;
   sdp_row_t    rows [5] = '{'{`SDP_REG_MASK, 32'h0001ffff}, '{`SDP_REG_COUNT, 32'h0},
                             '{`SDP_REG_STATUS, 32'h0}, '{`SDP_REG_BASE, 32'h0},
                             '{8'h10, 32'h0}};
   localparam logic [71:0] W1 = 72'ha5_0123_4567_89ab_cdef;
   localparam logic [71:0] W2 = 72'h3c_fedc_ba98_7654_3210;
   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;
   sdp_port dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
      .chip_sel_low_active(sel_lo), .chip_sel_high_active(sel_hi), .read_not_write(rnw),
      .out_en_n(oe_n), .address_strobe_n(strobe_n), .counter_advance_n(adv_n),
      .counter_clear_n(clr_n), .counter_or_mask_select(cm), .byte_lane_enable_n(be_n),
      .addr_in(addr_w), .addr_out(addr_out), .addr_oe(addr_oe),
      .data_in(data_w), .data_out(data_out), .data_oe(data_oe),
      .counter_wrap_flag_n(wrap_n), .msg_flag_n(msg_n),
      .far_mbox_wr(far_wr), .near_mbox_wr(near_wr),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack)
   );
   sdp_host_model host_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .host_a_en(host_a_en), .host_a(host_a),
      .host_d_en(host_d_en), .host_d(host_d), .addr_out(addr_out), .addr_oe(addr_oe),
      .data_out(data_out), .data_oe(data_oe), .addr_w(addr_w), .data_w(data_w)
   );
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // classic wishbone cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      wb_cyc <= 1;
      wb_stb <= 1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         n_mismatch++;
         stop_test();
      end
      q = wb_q;
      wb_cyc <= 0;
      wb_stb <= 0;
   endtask
   // one pin operation held for n edges, then back to a deselected hold
   task automatic op(input logic c1, input logic rw, input logic ld_n, input logic ad_n,
                     input logic cmv, input logic [16:0] a, input logic [7:0] be, input int n);
      @(posedge sys_clk);
      sel_hi <= c1;
      rnw <= rw;
      strobe_n <= ld_n;
      adv_n <= ad_n;
      cm <= cmv;
      host_a <= a;
      be_n <= be;
      host_a_en <= ld_n | ~ad_n;
      host_d_en <= ~rw;
      repeat (n) @(posedge sys_clk);
      sel_hi <= 0;
      rnw <= 1;
      strobe_n <= 1;
      adv_n <= 1;
      cm <= 1;
      host_a_en <= 0;
      host_d_en <= 0;
   endtask
   function automatic logic [71:0] lanes(input logic [7:0] be);
      logic [71:0] m;
      for (int b = 0; b < 8; b++) m[9*b +: 9] = {9{~be[b]}};
      return m;
   endfunction
   // single read at a loaded address; drive lasts exactly one cycle
   task automatic rd_chk(input logic c1, input logic [16:0] a, input logic [7:0] be,
                         input logic [71:0] exp, input logic [71:0] oe_exp);
      int n;
      op(c1, 1, 0, 0, 1, a, be, 1);
      n = 0;
      while (data_oe === '0 && n < 8) begin
         @(posedge sys_clk);
         n++;
      end
      chk(data_oe, oe_exp);
      chk(data_out & oe_exp, exp & oe_exp);
      @(posedge sys_clk);
      chk(data_oe, '0);
   endtask
   task automatic wr(input logic [16:0] a, input logic [71:0] d);
      host_d <= d;
      op(1, 0, 0, 0, 1, a, 8'h00, 1);
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic rbk(input logic cmv, input logic [16:0] exp);
      op(0, 1, 0, 1, cmv, 17'h0, 8'hff, 1);
      k = 0;
      while (addr_oe === '0 && k < 8) begin
         @(posedge sys_clk);
         k++;
      end
      chk(addr_oe, {17{1'b1}});
      chk(addr_out, exp);
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic do_reset();
      rst_n <= 0;
      repeat (6) @(posedge sys_clk);
      chk({wrap_n, msg_n, near_wr, wb_ack}, 4'hc);
      chk({addr_oe, data_oe}, '0);
      rst_n <= 1;
      repeat (6) @(posedge sys_clk);
   endtask
   // hang guard
   initial begin
      #400000;
      n_mismatch++;
      stop_test();
   end
   // main sequence
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wb(0, rows[i].adr, 32'h0);
         chk(q, rows[i].exp);
      end
      wr(17'h00123, W1);
      rd_chk(1, 17'h00123, 8'h00, W1, {72{1'b1}});
      rd_chk(1, 17'h00123, 8'hf0, W1, lanes(8'hf0));
      oe_n <= 1;
      rd_chk(1, 17'h00123, 8'h00, W1, '0);
      oe_n <= 0;
      rd_chk(0, 17'h00123, 8'h00, W1, '0);
      sel_lo <= 1;
      rd_chk(1, 17'h00123, 8'h00, W1, '0);
      sel_lo <= 0;
      wr(17'h00123, W1);
      // read straight into a write: the pending read drive is dropped
      @(posedge sys_clk);
      sel_hi <= 1;
      strobe_n <= 0;
      adv_n <= 0;
      host_a <= 17'h00123;
      be_n <= 8'h00;
      host_a_en <= 1;
      @(posedge sys_clk);
      rnw <= 0;
      host_a <= 17'h00000;
      host_d <= W2;
      host_d_en <= 1;
      @(posedge sys_clk);
      sel_hi <= 0;
      rnw <= 1;
      strobe_n <= 1;
      adv_n <= 1;
      host_a_en <= 0;
      host_d_en <= 0;
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         chk(data_oe, '0);
      end
      clr_n <= 0;
      rd_chk(1, 17'h00077, 8'h00, W2, {72{1'b1}});
      clr_n <= 1;
      repeat (3) @(posedge sys_clk);
      wb(0, `SDP_REG_COUNT, 32'h0);
      chk(q, 32'h0);
      wb(1, `SDP_REG_MASK, 32'h3);
      op(0, 1, 0, 0, 1, 17'h00010, 8'hff, 1);
      repeat (3) @(posedge sys_clk);
      rbk(1, 17'h00010);
      rbk(0, 17'h00003);
      op(0, 1, 1, 0, 1, 17'h0, 8'hff, 3);
      repeat (4) @(posedge sys_clk);
      chk(wrap_n, 1'b0);
      wb(0, `SDP_REG_COUNT, 32'h0);
      chk(q, 32'h13);
      op(0, 1, 1, 0, 1, 17'h0, 8'hff, 1);
      repeat (4) @(posedge sys_clk);
      wb(0, `SDP_REG_COUNT, 32'h0);
      chk(q, 32'h10);
      do_reset();
      // the array keeps no reset, so give the mailbox word a known value
      wr(17'(`SDP_MBOX_OWN), W1);
      far_wr <= 1;
      @(posedge sys_clk);
      far_wr <= 0;
      repeat (2) @(posedge sys_clk);
      chk(msg_n, 1'b0);
      rd_chk(1, 17'(`SDP_MBOX_OWN), 8'hff, '0, '0);
      repeat (2) @(posedge sys_clk);
      chk(msg_n, 1'b0);
      rd_chk(1, 17'(`SDP_MBOX_OWN), 8'hfe, W1, lanes(8'hfe));
      @(posedge sys_clk);
      chk(msg_n, 1'b1);
      host_d <= W1;
      op(1, 0, 0, 0, 1, 17'(`SDP_MBOX_FAR), 8'h7f, 1);
      k = 0;
      while (near_wr !== 1'b1 && k < 8) begin
         @(posedge sys_clk);
         k++;
      end
      chk(near_wr, 1'b1);
      @(posedge sys_clk);
      chk(near_wr, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
